//--- verilog/ipa_pkg.sv
// Constants for the pending and active bookkeeping block.
// Assumes a 32-bit Avalon-MM register slave with byte addresses.
package ipa_pkg;
	localparam int IPA_NUM_LINES = 200;
	localparam int IPA_NUM_WORDS = 7;
	localparam logic [11:0] IPA_OFS_SET = 12'h200;
	localparam logic [11:0] IPA_OFS_CLR = 12'h280;
	localparam logic [11:0] IPA_OFS_ACT = 12'h300;
	localparam logic [11:0] IPA_OFS_BANK_SPAN = 12'h080;
	localparam logic [31:0] IPA_RESET_WORD = 32'h0000_0000;
	localparam logic [31:0] IPA_UNMAPPED_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {
		IPA_BANK_SET,
		IPA_BANK_CLR,
		IPA_BANK_ACT,
		IPA_BANK_NONE
	} ipa_bank_t;
endpackage

//--- verilog/ipa_line.sv
// One interrupt line's pending bit.
// Assumes set, clear and acknowledge come from the same clock domain.
`timescale 1ns/1ps
module ipa_line
	import ipa_pkg::*;
(
	input wire logic core_clk, // system clock
	input wire logic rst_n, // synchronised reset, active low
	input wire logic sw_set, // software one written to set bank
	input wire logic sw_clr, // software one written to clear bank
	input wire logic hw_req, // synchronised interrupt input
	input wire logic ack, // exception entry taken for this line
	output logic force_pending_set // pending state
);
	logic force_pending_set_q;
	logic force_pending_set_d;
	logic set_any;
	logic clr_any;

	assign set_any = sw_set | hw_req;
	assign clr_any = sw_clr | ack;
	// A set arriving with a clear wins, so no event is lost.
	assign force_pending_set_d = set_any ? 1'b1 : (clr_any ? 1'b0 : force_pending_set_q);
	assign force_pending_set = force_pending_set_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			force_pending_set_q <= 1'b0;
		end else begin
			force_pending_set_q <= force_pending_set_d;
		end
	end
endmodule

//--- verilog/ipa_top.sv
// Pending and active state registers for a 200-line interrupt controller.
// Assumes an Avalon-MM master with a privilege qualifier, and neighbouring
// blocks that supply exception entry and exit per line.
// What this block does
// - Bank accesses are honoured only when the master is privileged.
// - Line k sits in word k/32 at bit k mod 32 for lines 0 to 199.
// - A one written to the set bank makes the line pending even if disabled.
// - Setting an already pending line changes nothing.
// - Zeros written to set or clear banks have no effect.
// - Both set and clear banks read back the pending state.
// - Only the clear bank and exception entry clear a pending bit, never the set bank.
// - A one written to the clear bank removes the pending state unless the line's synchronised input is high in that cycle.
// - Clearing pending does not touch the active state.
// - The active bank is read-only and reports each line's active state.
// - All bank words read zero after reset.
// - Banks sit at 200h, 280h and 300h, words four bytes apart.
// - An active bit reads one when active, also when active and pending.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ipa_top
	import ipa_pkg::*;
#(
	parameter int NUM_LINES = IPA_NUM_LINES
)(
	input wire logic core_clk, // system clock, 20 MHz
	input wire logic reset_n, // asynchronous reset, active low
	input wire logic [11:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	input wire logic avs_privileged, // master in privileged mode
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic [NUM_LINES-1:0] irq_in, // interrupt input lines
	input wire logic [NUM_LINES-1:0] exc_entry, // exception entry pulse
	input wire logic [NUM_LINES-1:0] exc_exit, // exception return pulse
	output logic [NUM_LINES-1:0] pending, // pending state per line
	output logic [NUM_LINES-1:0] active // active state per line
);
	localparam int NW = (NUM_LINES + 31) / 32;
	localparam int PADW = NW * 32;
	localparam int TOP = NUM_LINES - 1;
	localparam int TOP_W = TOP / 32;
	localparam int TOP_BIT = TOP % 32;
	localparam logic [2:0] TOP_WORD = 3'(TOP_W);

	// The word index is three bits wide, so seven words is the most served.
	if (NUM_LINES < 1 || NW > IPA_NUM_WORDS) begin : g_bad_size
		$error("ipa_top: NUM_LINES out of range");
	end

	logic rst_m_q;
	logic rst_q;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_m_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_q <= rst_m_q;
		end
	end

	// Interrupt inputs come from other logic; they are synchronised anyway
	// since sources may sit on other clocks.
	logic [NUM_LINES-1:0] irq_m_q;
	logic [NUM_LINES-1:0] irq_s_q;
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			irq_m_q <= '0;
			irq_s_q <= '0;
		end else begin
			irq_m_q <= irq_in;
			irq_s_q <= irq_m_q;
		end
	end

	// Bus decode.
	wire [11:0] bank_base = {avs_address[11:7], 7'h00};
	wire [2:0] word_idx = avs_address[4:2];
	wire in_word = (avs_address[6:5] == 2'b00) && (word_idx < 3'(NW));
	ipa_bank_t bank;
	assign bank = !in_word ? IPA_BANK_NONE :
		(bank_base == IPA_OFS_SET) ? IPA_BANK_SET :
		(bank_base == IPA_OFS_CLR) ? IPA_BANK_CLR :
		(bank_base == IPA_OFS_ACT) ? IPA_BANK_ACT : IPA_BANK_NONE;
	wire priv_ok = avs_privileged;
	wire wr_ok = avs_write && priv_ok;
	wire rd_ok = avs_read && priv_ok;

	wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] wr_ones = avs_writedata & be_mask;

	// Expand the written word onto its lines; bits past the last line drop.
	logic [PADW-1:0] set_pad;
	logic [PADW-1:0] clr_pad;
	always_comb begin
		set_pad = '0;
		clr_pad = '0;
		for (int w = 0; w < NW; w++) begin
			if (wr_ok && word_idx == 3'(w) && bank == IPA_BANK_SET) begin
				set_pad[w*32 +: 32] = wr_ones;
			end
			if (wr_ok && word_idx == 3'(w) && bank == IPA_BANK_CLR) begin
				clr_pad[w*32 +: 32] = wr_ones;
			end
		end
	end

	// Pending bits, one cell per line.
	genvar g;
	generate
		for (g = 0; g < NUM_LINES; g++) begin : g_line
			ipa_line u_line (
				.core_clk(core_clk),
				.rst_n(rst_q),
				.sw_set(set_pad[g]),
				.sw_clr(clr_pad[g]),
				.hw_req(irq_s_q[g]),
				.ack(exc_entry[g]),
				.force_pending_set(pending[g])
			);
		end
	endgenerate

	// Active state is owned by exception entry and exit, never by the bus;
	// writes to the active bank are simply dropped.
	logic [NUM_LINES-1:0] act_q;
	logic [NUM_LINES-1:0] act_d;
	assign act_d = (act_q & ~exc_exit) | exc_entry;
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			act_q <= '0;
		end else begin
			act_q <= act_d;
		end
	end
	assign active = act_q;

	// Read mux; lines beyond the last pad with zero.
	logic [PADW-1:0] force_pending_set_pad;
	logic [PADW-1:0] act_pad;
	assign force_pending_set_pad = PADW'(pending);
	assign act_pad = PADW'(act_q);
	logic [31:0] force_pending_set_word;
	logic [31:0] act_word;
	always_comb begin
		force_pending_set_word = IPA_UNMAPPED_WORD;
		act_word = IPA_UNMAPPED_WORD;
		for (int w = 0; w < NW; w++) begin
			if (word_idx == 3'(w)) begin
				force_pending_set_word = force_pending_set_pad[w*32 +: 32];
				act_word = act_pad[w*32 +: 32];
			end
		end
	end
	wire [31:0] rd_word = !rd_ok ? IPA_UNMAPPED_WORD :
		(bank == IPA_BANK_SET || bank == IPA_BANK_CLR) ? force_pending_set_word :
		(bank == IPA_BANK_ACT) ? act_word : IPA_UNMAPPED_WORD;

	// One wait cycle per read so read data comes from a flip-flop; writes
	// complete with no wait.
	logic rd_done_q;
	logic [31:0] rdata_q;
	always_ff @(posedge core_clk or negedge rst_q) begin
		if (!rst_q) begin
			rd_done_q <= 1'b0;
			rdata_q <= IPA_RESET_WORD;
		end else begin
			rd_done_q <= avs_read && !rd_done_q;
			rdata_q <= rd_word;
		end
	end
	assign avs_waitrequest = avs_read && !rd_done_q;
	assign avs_readdata = rdata_q;

	// The set, clear and read-back checks below watch the highest line, which
	// software reaches in the last word; a line that no access touches would leave them idle.
	property p_set_force_pending_set;
		@(posedge core_clk) disable iff (!rst_q)
		(wr_ok && bank == IPA_BANK_SET && word_idx == TOP_WORD
		&& wr_ones[TOP_BIT]) |=> pending[TOP];
	endproperty
	a_set_force_pending_set: assert property (p_set_force_pending_set) else $error("set lost");

	property p_clr_force_pending_set;
		@(posedge core_clk) disable iff (!rst_q)
		(wr_ok && bank == IPA_BANK_CLR && word_idx == TOP_WORD
		&& wr_ones[TOP_BIT] && !irq_s_q[TOP]) |=> !pending[TOP];
	endproperty
	a_clr_force_pending_set: assert property (p_clr_force_pending_set) else $error("clr lost");

	property p_set_no_clr;
		@(posedge core_clk) disable iff (!rst_q)
		(pending[TOP] && !clr_pad[TOP] && !exc_entry[TOP]) |=> pending[TOP];
	endproperty
	a_set_no_clr: assert property (p_set_no_clr)
		else $error("pending dropped");

	property p_clr_keeps_act;
		@(posedge core_clk) disable iff (!rst_q)
		(|clr_pad && exc_entry == '0 && exc_exit == '0) |=> $stable(act_q);
	endproperty
	a_clr_keeps_act: assert property (p_clr_keeps_act)
		else $error("active changed");

	property p_unpriv;
		@(posedge core_clk) disable iff (!rst_q)
		(avs_write && !avs_privileged) |-> (set_pad == '0 && clr_pad == '0);
	endproperty
	a_unpriv: assert property (p_unpriv) else $error("unpriv write");

	property p_read_force_pending_set;
		@(posedge core_clk) disable iff (!rst_q)
		(rd_ok && bank == IPA_BANK_CLR && word_idx == TOP_WORD
		&& !avs_waitrequest && $stable(pending))
		|-> avs_readdata[7:0] == force_pending_set_pad[TOP_W*32 +: 8];
	endproperty
	a_read_force_pending_set: assert property (p_read_force_pending_set)
		else $error("force_pending_set read");

	property p_hi_zero;
		@(posedge core_clk) disable iff (!rst_q)
		(avs_read && !avs_waitrequest && $past(word_idx) == 3'd6)
		|-> avs_readdata[31:8] == 24'h000000;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("pad bits");

	property p_act;
		@(posedge core_clk) disable iff (!rst_q)
		(exc_entry != '0)
		|=> ((active & $past(exc_entry)) == $past(exc_entry));
	endproperty
	a_act: assert property (p_act)
		else $error("active missed");

	property p_reset_zero;
		@(posedge core_clk) $rose(rst_q)
		|-> (pending == '0 && active == '0 && avs_readdata == IPA_RESET_WORD);
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("state not cleared by reset");

	property p_act_ro;
		@(posedge core_clk) disable iff (!rst_q)
		(exc_entry == '0 && exc_exit == '0) |=> $stable(act_q);
	endproperty
	a_act_ro: assert property (p_act_ro)
		else $error("active moved without entry or exit");

	property p_exit_clears;
		@(posedge core_clk) disable iff (!rst_q)
		(exc_exit != '0 && exc_entry == '0)
		|=> ((active & $past(exc_exit)) == '0);
	endproperty
	a_exit_clears: assert property (p_exit_clears)
		else $error("active kept after exit");

	property p_ack_clears;
		@(posedge core_clk) disable iff (!rst_q)
		(exc_entry != '0 && set_pad == '0 && irq_s_q == '0)
		|=> ((pending & $past(exc_entry)) == '0);
	endproperty
	a_ack_clears: assert property (p_ack_clears)
		else $error("pending kept after entry");

	property p_irq_sets;
		@(posedge core_clk) disable iff (!rst_q)
		(irq_s_q != '0)
		|=> ((pending & $past(irq_s_q)) == $past(irq_s_q));
	endproperty
	a_irq_sets: assert property (p_irq_sets)
		else $error("input did not set pending");

	property p_zero_write;
		@(posedge core_clk) disable iff (!rst_q)
		(wr_ok && wr_ones == 32'h0000_0000 && irq_s_q == '0
		&& exc_entry == '0 && exc_exit == '0)
		|=> ($stable(pending) && $stable(act_q));
	endproperty
	a_zero_write: assert property (p_zero_write)
		else $error("zero write changed state");

	property p_unpriv_read;
		@(posedge core_clk) disable iff (!rst_q)
		(avs_read && !avs_waitrequest && !$past(avs_privileged))
		|-> avs_readdata == IPA_UNMAPPED_WORD;
	endproperty
	a_unpriv_read: assert property (p_unpriv_read)
		else $error("unprivileged read returned data");

	property p_rd_one_wait;
		@(posedge core_clk) disable iff (!rst_q)
		(avs_read && avs_waitrequest) |=> (!avs_waitrequest || !avs_read);
	endproperty
	a_rd_one_wait: assert property (p_rd_one_wait)
		else $error("read stalled too long");

	property p_write_nowait;
		@(posedge core_clk) disable iff (!rst_q)
		avs_write |-> !avs_waitrequest;
	endproperty
	a_write_nowait: assert property (p_write_nowait)
		else $error("write stalled");

	property p_unmapped_read;
		@(posedge core_clk) disable iff (!rst_q)
		(avs_read && !avs_waitrequest && $past(bank) == IPA_BANK_NONE)
		|-> avs_readdata == IPA_UNMAPPED_WORD;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read returned data");

	property p_unmapped_write;
		@(posedge core_clk) disable iff (!rst_q)
		(wr_ok && bank == IPA_BANK_NONE) |-> (set_pad == '0 && clr_pad == '0);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write)
		else $error("unmapped write reached a line");

	property p_set_not_clr;
		@(posedge core_clk) disable iff (!rst_q)
		(wr_ok && bank == IPA_BANK_SET) |-> clr_pad == '0;
	endproperty
	a_set_not_clr: assert property (p_set_not_clr)
		else $error("set bank write cleared a line");

	property p_clr_not_set;
		@(posedge core_clk) disable iff (!rst_q)
		(wr_ok && bank == IPA_BANK_CLR) |-> set_pad == '0;
	endproperty
	a_clr_not_set: assert property (p_clr_not_set)
		else $error("clear bank write set a line");
endmodule

//--- sim/ipa_core_model.sv
// Core model issuing Avalon-MM register accesses, privileged or not.
// Assumes a slave that stalls through waitrequest on core_clk.
`timescale 1ns/1ps
module ipa_core_model (
	input wire logic core_clk, // system clock
	input wire logic avs_waitrequest, // slave stall
	input wire logic [31:0] avs_readdata, // slave read data
	output logic [11:0] avs_address, // byte address
	output logic avs_read, // read request
	output logic avs_write, // write request
	output logic [31:0] avs_writedata, // write data
	output logic [3:0] avs_byteenable, // byte lanes
	output logic avs_privileged // privilege qualifier
);
	initial begin
		avs_address = 12'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		avs_privileged = 1'b1;
	end

	// Never aims a write at the active bank.
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic p, output logic [31:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_privileged <= p;
		@(posedge core_clk);
		while (avs_waitrequest) @(posedge core_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Stale data is inverted so nothing relies on a held bus.
		avs_writedata <= ~d;
	endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the pending and active bookkeeping block.
// Assumes the core model in ipa_core_model drives the register bus.
`timescale 1ns/1ps
module tb_top;
	import ipa_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [199:0] irq_in = '0, exc_entry = '0, exc_exit = '0;
	logic [11:0] avs_address;
	logic avs_read, avs_write, avs_privileged, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic [199:0] pending, active;
	int n_mismatch = 0;
	int checked = 0;
	localparam logic [11:0] S = IPA_OFS_SET, C = IPA_OFS_CLR;
	localparam logic [11:0] A = IPA_OFS_ACT;

	always #25 core_clk = ~core_clk;

	ipa_top dut_u (.core_clk, .reset_n, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_privileged,
		.avs_readdata, .avs_waitrequest, .irq_in, .exc_entry,
		.exc_exit, .pending, .active);
	ipa_core_model core_u (.core_clk, .avs_waitrequest, .avs_readdata,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_privileged);

	task automatic chk(input string s, input logic [31:0] v, e);
		checked++;
		if (v !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", s, e, v);
		end
	endtask

	task automatic wrap_up;
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		core_u.acc(1'b0, a, 32'h0000_0000, 1'b1, q);
		chk($sformatf("word %h", a), q, e);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		core_u.acc(1'b1, a, d, 1'b1, q);
	endtask

	task automatic pulse(input logic ent, input int k);
		@(posedge core_clk);
		if (ent) exc_entry[k] <= 1'b1;
		else exc_exit[k] <= 1'b1;
		@(posedge core_clk);
		exc_entry[k] <= 1'b0;
		exc_exit[k] <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	task automatic t_reset;
		for (int w = 0; w < IPA_NUM_WORDS; w++) begin
			rd(S + 12'(4 * w), IPA_RESET_WORD);
			rd(C + 12'(4 * w), IPA_RESET_WORD);
			rd(A + 12'(4 * w), IPA_RESET_WORD);
		end
	endtask

	task automatic t_set_clear;
		wr(S + 12'h018, 32'hFFFF_FFFF);
		rd(S + 12'h018, 32'h0000_00FF);
		rd(C + 12'h018, 32'h0000_00FF);
		chk("pending 199:192", {24'h0, pending[199:192]}, 32'hFF);
		wr(S + 12'h018, 32'h0000_0001);
		wr(S + 12'h018, 32'h0000_0000);
		wr(C + 12'h018, 32'h0000_0000);
		rd(S + 12'h018, 32'h0000_00FF);
		wr(C + 12'h018, 32'h0000_0081);
		rd(C + 12'h018, 32'h0000_007E);
	endtask

	task automatic t_refused;
		core_u.acc(1'b1, S, 32'h0000_0001, 1'b0, q);
		core_u.acc(1'b0, S, 32'h0000_0000, 1'b0, q);
		chk("unprivileged read", q, 32'h0000_0000);
		wr(12'h220, 32'h0000_0001);
		rd(S, 32'h0000_0000);
		rd(12'h220, IPA_UNMAPPED_WORD);
	endtask

	task automatic t_active;
		@(posedge core_clk);
		irq_in[37] <= 1'b1;
		repeat (4) @(posedge core_clk);
		irq_in[37] <= 1'b0;
		rd(S + 12'h004, 32'h0000_0020);
		pulse(1'b1, 37);
		chk("active 37", {31'h0, active[37]}, 32'h0000_0001);
		rd(A + 12'h004, 32'h0000_0020);
		rd(S + 12'h004, 32'h0000_0000);
		wr(S + 12'h004, 32'h0000_0020);
		rd(A + 12'h004, 32'h0000_0020);
		wr(C + 12'h004, 32'h0000_0020);
		rd(A + 12'h004, 32'h0000_0020);
		rd(C + 12'h004, 32'h0000_0000);
		pulse(1'b0, 37);
		chk("active 37", {31'h0, active[37]}, 32'h0000_0000);
		rd(A + 12'h004, 32'h0000_0000);
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_set_clear();
		t_refused();
		t_active();
		wrap_up();
	end

	// The whole run needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		wrap_up();
	end
endmodule
